// ==== hdl/core_ctx_pkg.sv ====
// Package with constants and carrier types for the core stack and indirect pointer block.
package core_ctx_pkg;

  // ----------------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------------
  localparam int STACK_DEPTH  = 16;
  localparam int STACK_WIDTH  = 15;
  localparam int SP_WIDTH     = 5;
  localparam int PTR_WIDTH    = 16;
  localparam int DATA_WIDTH   = 8;
  localparam int LIN_WIDTH    = 12;
  localparam int SHADOW_WIDTH = 40;
  localparam int OPCODE_COUNT = 50;
  localparam int OPC_WIDTH    = 6;

  localparam logic [SP_WIDTH-1:0]  SP_EMPTY    = 5'h00;
  localparam logic [SP_WIDTH-1:0]  SP_FULL     = 5'h10;
  localparam logic [SP_WIDTH-1:0]  SP_ONE      = 5'h01;
  localparam logic [OPC_WIDTH-1:0] OPC_LIMIT   = 6'h32;

  // ----------------------------------------------------------------------
  // Address map of the unified pointer space
  // ----------------------------------------------------------------------
  localparam logic [PTR_WIDTH-1:0] PROG_BASE   = 16'h8000;
  localparam logic [PTR_WIDTH-1:0] LIN_BASE    = 16'h2000;
  localparam logic [PTR_WIDTH-1:0] LIN_END     = 16'h2FFF;
  localparam logic [PTR_WIDTH-1:0] PTR_RESET   = 16'h0000;
  localparam logic [STACK_WIDTH-1:0] ADDR_ZERO = 15'h0000;
  localparam logic [DATA_WIDTH-1:0] DATA_ZERO  = 8'h00;
  localparam logic [SHADOW_WIDTH-1:0] SHADOW_ZERO = 40'h00_0000_0000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_WAIT = 2'b01,
    ACC_DONE = 2'b10
  } access_state_e;

  typedef struct packed {
    logic                   call_req;
    logic                   irq_entry;
    logic                   ret_req;
    logic                   irq_return;
    logic [STACK_WIDTH-1:0] push_addr;
  } stack_cmd_s;

  typedef struct packed {
    logic                 valid;
    logic                 sel;
    logic                 write;
    logic                 load_ptr;
    logic [PTR_WIDTH-1:0] load_value;
    logic [DATA_WIDTH-1:0] wdata;
  } indirect_req_s;

endpackage : core_ctx_pkg

// ==== hdl/core_ctx.sv ====
// Return stack, context shadows, indirect pointers and opcode check of the core.
`timescale 1ns/100ps
`default_nettype none
module core_ctx
  import core_ctx_pkg::*;
(
  input  wire logic                    CLK,
  input  wire logic                    RST,
  input  wire logic                    CYCLE_EN,
  input  wire logic                    STACK_RESET_EN,
  input  wire stack_cmd_s              STACK_CMD,
  input  wire logic                    FLAG_CLEAR,
  output logic [STACK_WIDTH-1:0]       RETURN_ADDR,
  output logic                         STACK_OVERFLOW_FLAG,
  output logic                         STACK_UNDERFLOW_FLAG,
  output logic                         SOFT_RESET,
  output logic [SP_WIDTH-1:0]          STACK_LEVEL,
  input  wire logic [SHADOW_WIDTH-1:0] CORE_CONTEXT,
  output logic [SHADOW_WIDTH-1:0]      RESTORE_CONTEXT,
  output logic                         RESTORE_VALID,
  input  wire indirect_req_s           IND_REQ,
  output logic [PTR_WIDTH-1:0]         INDIRECT_POINTER0,
  output logic [PTR_WIDTH-1:0]         INDIRECT_POINTER1,
  output logic [PTR_WIDTH-1:0]         MEM_ADDR,
  output logic                         MEM_IS_PROG,
  output logic                         MEM_IS_LINEAR,
  output logic [LIN_WIDTH-1:0]         LINEAR_OFFSET,
  output logic                         MEM_RD,
  output logic                         MEM_WR,
  output logic [DATA_WIDTH-1:0]        MEM_WDATA,
  input  wire logic [DATA_WIDTH-1:0]   MEM_RDATA,
  output logic [DATA_WIDTH-1:0]        INDIRECT_DATA_PORT,
  output logic                         IND_DONE,
  output logic                         IND_STALL,
  input  wire logic [OPC_WIDTH-1:0]    OPCODE,
  output logic                         OPCODE_ILLEGAL
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [SP_WIDTH-1:0]     sp;
    logic                    ovf;
    logic                    unf;
    logic                    soft_rst;
    logic [STACK_WIDTH-1:0]  ret_addr;
    logic [SHADOW_WIDTH-1:0] shadow;
    logic [SHADOW_WIDTH-1:0] restore;
    logic                    restore_valid;
    logic [PTR_WIDTH-1:0]    ptr0;
    logic [PTR_WIDTH-1:0]    ptr1;
    access_state_e           acc;
    logic [PTR_WIDTH-1:0]    addr;
    logic                    is_prog;
    logic                    rd;
    logic                    wr;
    logic [DATA_WIDTH-1:0]   wdata;
    logic [DATA_WIDTH-1:0]   rdata;
    logic                    done;
    logic                    illegal;
  } core_state_s;

  core_state_s              cur;
  core_state_s              next_cur;
  logic [STACK_WIDTH-1:0]   stack_mem [STACK_DEPTH];

  logic do_push;
  logic do_pop;
  logic push_ok;
  logic pop_ok;
  logic [PTR_WIDTH-1:0] sel_ptr;
  logic [SP_WIDTH-2:0]  push_idx;

  assign do_push = CYCLE_EN && (STACK_CMD.call_req || STACK_CMD.irq_entry);
  assign do_pop  = CYCLE_EN && (STACK_CMD.ret_req || STACK_CMD.irq_return);
  assign push_ok = do_push && (cur.sp != SP_FULL);
  assign pop_ok  = do_pop && (cur.sp != SP_EMPTY);
  assign sel_ptr = IND_REQ.sel ? cur.ptr1 : cur.ptr0;
  // Unless the stack is full or empty, a push in the same cycle as a pop replaces the entry that the pop removes.
  assign push_idx = pop_ok ? (cur.sp[SP_WIDTH-2:0] - SP_ONE[SP_WIDTH-2:0])
                           : cur.sp[SP_WIDTH-2:0];

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_cur               = cur;
    next_cur.soft_rst      = 1'b0;
    next_cur.restore_valid = 1'b0;
    next_cur.done          = 1'b0;
    next_cur.rd            = 1'b0;
    next_cur.wr            = 1'b0;
    if (FLAG_CLEAR)
    begin
      next_cur.ovf = 1'b0;
      next_cur.unf = 1'b0;
    end
    if (push_ok)
    begin
      next_cur.sp = cur.sp + SP_ONE;
    end
    else if (do_push)
    begin
      next_cur.ovf      = 1'b1;
      next_cur.soft_rst = STACK_RESET_EN;
    end
    if (pop_ok)
    begin
      next_cur.sp       = push_ok ? cur.sp : cur.sp - SP_ONE;
      next_cur.ret_addr = stack_mem[cur.sp[SP_WIDTH-2:0] - SP_ONE[SP_WIDTH-2:0]];
    end
    else if (do_pop)
    begin
      next_cur.unf      = 1'b1;
      next_cur.ret_addr = ADDR_ZERO;
      next_cur.soft_rst = STACK_RESET_EN;
    end
    if (CYCLE_EN && STACK_CMD.irq_entry)
    begin
      next_cur.shadow = CORE_CONTEXT;
    end
    if (CYCLE_EN && STACK_CMD.irq_return)
    begin
      next_cur.restore       = cur.shadow;
      next_cur.restore_valid = 1'b1;
    end
    if (IND_REQ.load_ptr && cur.acc == ACC_IDLE)
    begin
      if (IND_REQ.sel)
        next_cur.ptr1 = IND_REQ.load_value;
      else
        next_cur.ptr0 = IND_REQ.load_value;
    end
    next_cur.illegal = CYCLE_EN ? (OPCODE >= OPC_LIMIT) : cur.illegal;
    unique case (cur.acc)
      ACC_IDLE:
      begin
        if (CYCLE_EN && IND_REQ.valid)
        begin
          next_cur.addr    = sel_ptr;
          next_cur.is_prog = (sel_ptr >= PROG_BASE);
          next_cur.wdata   = IND_REQ.wdata;
          if (sel_ptr >= PROG_BASE)
          begin
            next_cur.rd  = 1'b1;
            next_cur.acc = ACC_WAIT;
          end
          else
          begin
            next_cur.rd  = !IND_REQ.write;
            next_cur.wr  = IND_REQ.write;
            next_cur.acc = ACC_DONE;
          end
        end
      end
      ACC_WAIT:
      begin
        if (CYCLE_EN)
          next_cur.acc = ACC_DONE;
      end
      ACC_DONE:
      begin
        next_cur.rdata = cur.wr ? DATA_ZERO : MEM_RDATA;
        next_cur.done  = 1'b1;
        next_cur.acc   = ACC_IDLE;
      end
      default:
        next_cur.acc = ACC_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cur <= '{sp: SP_EMPTY, ret_addr: ADDR_ZERO, shadow: SHADOW_ZERO,
               restore: SHADOW_ZERO, ptr0: PTR_RESET, ptr1: PTR_RESET,
               acc: ACC_IDLE, addr: PTR_RESET, wdata: DATA_ZERO,
               rdata: DATA_ZERO, default: 1'b0};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // The stack array is kept apart from data memory and is not reset.
  always_ff @(posedge CLK)
  begin
    if (!RST && push_ok)
      stack_mem[push_idx] <= STACK_CMD.push_addr;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign RETURN_ADDR          = cur.ret_addr;
  assign STACK_OVERFLOW_FLAG  = cur.ovf;
  assign STACK_UNDERFLOW_FLAG = cur.unf;
  assign SOFT_RESET           = cur.soft_rst;
  assign STACK_LEVEL          = cur.sp;
  assign RESTORE_CONTEXT      = cur.restore;
  assign RESTORE_VALID        = cur.restore_valid;
  assign INDIRECT_POINTER0    = cur.ptr0;
  assign INDIRECT_POINTER1    = cur.ptr1;
  assign MEM_ADDR             = cur.addr;
  assign MEM_IS_PROG          = cur.is_prog;
  // Linear window maps a flat range onto banked general-purpose memory.
  assign MEM_IS_LINEAR        = !cur.is_prog && cur.addr >= LIN_BASE && cur.addr <= LIN_END;
  assign LINEAR_OFFSET        = cur.addr[LIN_WIDTH-1:0];
  assign MEM_RD               = cur.rd;
  assign MEM_WR               = cur.wr && !cur.is_prog;
  assign MEM_WDATA            = cur.wdata;
  assign INDIRECT_DATA_PORT   = cur.rdata;
  assign IND_DONE             = cur.done;
  assign IND_STALL            = (cur.acc != ACC_IDLE);
  assign OPCODE_ILLEGAL       = cur.illegal;

endmodule : core_ctx
`default_nettype wire

// ==== test/core_ctx_assertions.sv ====
// Port checker for the core_ctx stack, indirect access and opcode timing.
`timescale 1ns/100ps
`default_nettype none
module core_ctx_assertions
  import core_ctx_pkg::*;
(
  input wire logic                   CLK,
  input wire logic                   RST,
  input wire logic                   CYCLE_EN,
  input wire logic                   STACK_RESET_EN,
  input wire logic                   SOFT_RESET,
  input wire logic                   STACK_OVERFLOW_FLAG,
  input wire logic                   STACK_UNDERFLOW_FLAG,
  input wire logic                   IND_DONE,
  input wire logic                   MEM_RD,
  input wire logic                   MEM_WR,
  input wire logic                   MEM_IS_PROG,
  input wire logic                   MEM_IS_LINEAR,
  input wire logic                   OPCODE_ILLEGAL,
  input wire stack_cmd_s             STACK_CMD,
  input wire logic [SP_WIDTH-1:0]    STACK_LEVEL,
  input wire logic [STACK_WIDTH-1:0] RETURN_ADDR,
  input wire logic [PTR_WIDTH-1:0]   MEM_ADDR,
  input wire logic [OPC_WIDTH-1:0]   OPCODE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  wire psh = CYCLE_EN && (STACK_CMD.call_req || STACK_CMD.irq_entry);
  wire pop = CYCLE_EN && (STACK_CMD.ret_req || STACK_CMD.irq_return);
  wire ovf = psh && !pop && STACK_LEVEL == SP_FULL;
  wire unf = pop && !psh && STACK_LEVEL == SP_EMPTY;
  property p_push; psh && !pop && !ovf |=> STACK_LEVEL == $past(STACK_LEVEL) + SP_ONE; endproperty
  a_push: assert property (p_push) else $error("push level");
  property p_ovf; ovf |=> STACK_OVERFLOW_FLAG && STACK_LEVEL == SP_FULL; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow");
  property p_unf; unf |=> STACK_UNDERFLOW_FLAG && RETURN_ADDR == ADDR_ZERO; endproperty
  a_unf: assert property (p_unf) else $error("underflow");
  property p_srst; STACK_RESET_EN && (ovf || unf) |=> SOFT_RESET; endproperty
  a_srst: assert property (p_srst) else $error("soft reset");
  property p_opc; CYCLE_EN |=> OPCODE_ILLEGAL == ($past(OPCODE) >= OPC_LIMIT); endproperty
  a_opc: assert property (p_opc) else $error("opcode");
  property p_lin; MEM_IS_LINEAR == (MEM_ADDR >= LIN_BASE && MEM_ADDR <= LIN_END); endproperty
  a_lin: assert property (p_lin) else $error("linear");
  property p_data; (MEM_RD || MEM_WR) && !MEM_IS_PROG |=> IND_DONE; endproperty
  a_data: assert property (p_data) else $error("data done");
  property p_prog; MEM_RD && MEM_IS_PROG && CYCLE_EN |=> !IND_DONE ##1 IND_DONE; endproperty
  a_prog: assert property (p_prog) else $error("program done");
  c_ovf: cover property (ovf);
  c_srst: cover property (SOFT_RESET);
  c_prog: cover property (MEM_RD && MEM_IS_PROG);
endmodule : core_ctx_assertions
bind core_ctx core_ctx_assertions chk (.*);
`default_nettype wire

// ==== test/test_core_ctx.sv ====
// Self-checking bench for core_ctx.
`timescale 1ns/100ps
`default_nettype none
module test_core_ctx import core_ctx_pkg::*; ;
  logic          CLK = 1'h0, RST = 1'h1, CYCLE_EN = 1'h0, STACK_RESET_EN = 1'h0, FLAG_CLEAR = 1'h0;
  stack_cmd_s    STACK_CMD = '0;
  indirect_req_s IND_REQ = '0;
  logic [39:0]   CORE_CONTEXT = '0, RESTORE_CONTEXT;
  logic [7:0]    MEM_RDATA = '0, MEM_WDATA, INDIRECT_DATA_PORT;
  logic [5:0]    OPCODE = '0;
  logic [14:0]   RETURN_ADDR;
  logic [4:0]    STACK_LEVEL;
  logic [15:0]   INDIRECT_POINTER0, INDIRECT_POINTER1, MEM_ADDR, cap;
  logic [16:0]   seen_addr;
  logic [11:0]   LINEAR_OFFSET;
  logic          STACK_OVERFLOW_FLAG, STACK_UNDERFLOW_FLAG, SOFT_RESET, RESTORE_VALID, IND_DONE;
  logic          MEM_IS_PROG, MEM_IS_LINEAR, MEM_RD, MEM_WR, IND_STALL, OPCODE_ILLEGAL;
  int            errors = 0, n_tests = 0;
  always #12.5 CLK = ~CLK;
  core_ctx uut (.*);
  task chk(input string nm, input logic [39:0] seen, exp);
    n_tests++;
    errors += (seen !== exp);
    if (seen !== exp) $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
  endtask : chk
  task give_verdict;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task step(input logic [3:0] k, input logic [14:0] a);
    STACK_CMD = {k, a};
    @(negedge CLK);
  endtask : step
  task ireq(input logic [3:0] k, input logic [15:0] v, input logic [7:0] d);
    IND_REQ = {k, v, d};
    @(negedge CLK);
    cap = {MEM_RD, MEM_WR, MEM_IS_LINEAR, MEM_IS_PROG, LINEAR_OFFSET};
    seen_addr = {IND_STALL, MEM_ADDR};
    IND_REQ = '0;
    @(negedge CLK);
  endtask : ireq
  task automatic acc(input logic [3:0] k, input logic [7:0] d, output int n);
    ireq(k, 16'h0000, d);
    for (n = 0; n < 9 && IND_DONE !== 1'h1; n++) @(negedge CLK);
    errors += (n == 9);
    if (n == 9) give_verdict;
  endtask : acc
  task automatic t_stack;
    for (int i = 0; i < 16; i++) step(4'h8, 15'h0100 + 15'(i));
    chk("lvl", STACK_LEVEL, 5'h10);
    step(4'h8, 15'h7FFF);
    chk("ovf", {STACK_OVERFLOW_FLAG, SOFT_RESET, STACK_LEVEL}, 7'h50);
    for (int i = 15; i >= 0; i--)
    begin
      step(4'h2, 15'h0000);
      chk("ret", RETURN_ADDR, 15'h0100 + 15'(i));
    end
    STACK_RESET_EN = 1'h1;
    step(4'h2, 15'h0000);
    chk("unf", {STACK_UNDERFLOW_FLAG, SOFT_RESET, RETURN_ADDR}, 17'h18000);
    FLAG_CLEAR = 1'h1;
    step(4'h0, 15'h0000);
    chk("clr", {STACK_OVERFLOW_FLAG, STACK_UNDERFLOW_FLAG, SOFT_RESET}, 3'h0);
    FLAG_CLEAR = 1'h0;
  endtask : t_stack
  task t_irq;
    CORE_CONTEXT = 40'hA5_1234_5678;
    step(4'h4, 15'h0ABC);
    CORE_CONTEXT = 40'h00_0000_0000;
    step(4'hA, 15'h0123);
    chk("cr", {STACK_LEVEL, RETURN_ADDR}, 20'h08ABC);
    step(4'h1, 15'h0000);
    chk("ctx", RESTORE_CONTEXT, 40'hA5_1234_5678);
    chk("rv", {RESTORE_VALID, RETURN_ADDR}, 16'h8123);
    step(4'h0, 15'h0000);
    chk("rvp", {RESTORE_VALID, STACK_LEVEL}, 6'h00);
  endtask : t_irq
  task automatic t_ind;
    int n0, n1;
    ireq(4'h1, 16'h2005, 8'h00);
    ireq(4'h5, 16'h8010, 8'h00);
    repeat (3) @(negedge CLK);
    chk("ptr", {INDIRECT_POINTER1, INDIRECT_POINTER0}, 32'h8010_2005);
    MEM_RDATA = 8'h3C;
    acc(4'h8, 8'h00, n0);
    chk("dat", {cap, INDIRECT_DATA_PORT}, 24'hA005_3C);
    chk("dadr", seen_addr, 17'h1_2005);
    chk("idle", IND_STALL, 1'h0);
    MEM_RDATA = 8'hC3;
    acc(4'hC, 8'h00, n1);
    chk("prg", {cap, INDIRECT_DATA_PORT}, 24'h9010_C3);
    chk("padr", seen_addr, 17'h1_8010);
    chk("xtra", n1, n0 + 1);
    acc(4'hA, 8'h5A, n0);
    chk("wr", {cap, MEM_WDATA}, 24'h6005_5A);
    chk("wrd", INDIRECT_DATA_PORT, 8'h00);
    acc(4'hE, 8'hA5, n1);
    chk("pwr", cap, 16'h9010);
  endtask : t_ind
  task t_rst;
    step(4'h8, 15'h0055);
    STACK_CMD = '0;
    chk("pre", STACK_LEVEL, 5'h01);
    RST = 1'h1;
    repeat (2) @(negedge CLK);
    RST = 1'h0;
    chk("rst2", {STACK_LEVEL, STACK_OVERFLOW_FLAG, STACK_UNDERFLOW_FLAG, SOFT_RESET, IND_STALL,
                 OPCODE_ILLEGAL, RETURN_ADDR}, 25'h0000000);
    step(4'h8, 15'h0077);
    STACK_CMD = '0;
    chk("post", STACK_LEVEL, 5'h01);
  endtask : t_rst
  task t_opc;
    for (int i = 0; i < 64; i++)
    begin
      OPCODE = 6'(i);
      @(negedge CLK);
      chk("opc", OPCODE_ILLEGAL, i >= OPCODE_COUNT);
    end
  endtask : t_opc
  initial
  begin
    repeat (16) @(negedge CLK);
    RST = 1'h0;
    CYCLE_EN = 1'h1;
    chk("rst", {STACK_LEVEL, STACK_OVERFLOW_FLAG, IND_DONE, MEM_RD}, 8'h00);
    t_stack;
    t_irq;
    t_ind;
    t_opc;
    t_rst;
    give_verdict;
  end
endmodule : test_core_ctx
`default_nettype wire
